// ### core/tpc_cfg.svh
// offsets, field positions and reset values of the tape transport panel control
`ifndef TPC_CFG_SVH
`define TPC_CFG_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define TPC_OFF_STATUS 8'h00
`define TPC_OFF_CTRL 8'h04
`define TPC_OFF_CMD 8'h08

// ****************************************************************
// control register fields
// ****************************************************************
`define TPC_CTRL_NINE 0
`define TPC_CTRL_LOAD 1
`define TPC_CTRL_RST 2'h1

// ****************************************************************
// command register fields (write one to fire)
// ****************************************************************
`define TPC_CMD_FWD 0
`define TPC_CMD_REV 1
`define TPC_CMD_REWIND 2
`define TPC_CMD_RESET 3
`define TPC_CMD_ONLINE 4
`define TPC_CMD_OFFLINE 5

// ****************************************************************
// status register fields
// ****************************************************************
`define TPC_ST_LOADED 0
`define TPC_ST_READY 1
`define TPC_ST_SELECT 2
`define TPC_ST_LOAD_PT 3
`define TPC_ST_END_PT 4
`define TPC_ST_WR_LOCK 5
`define TPC_ST_WR_STATUS 6
`define TPC_ST_NINE 7
`define TPC_ST_REWIND 8
`define TPC_ST_RESET 9
`define TPC_ST_ONLINE 10
`define TPC_ST_FWD 11
`define TPC_ST_REV 12
`define TPC_ST_LOADING 13
`define TPC_ST_ADDR 16

// ****************************************************************
// unit address range
// ****************************************************************
`define TPC_ADDR_MAX 4'h8

`endif

// ### core/tpc_pkg.sv
// types shared by the tape transport panel control
package tpc_pkg;
	typedef logic [3:0] tpc_unit_t; // unit address 0 to 8
	typedef enum logic [1:0] {
		TPC_L_OFF,
		TPC_L_LOADING,
		TPC_L_OPERABLE
	} tpc_load_e; // load sequence states
	typedef enum logic [1:0] {
		TPC_M_IDLE,
		TPC_M_FWD,
		TPC_M_REV,
		TPC_M_REW
	} tpc_motion_e; // tape motion states
endpackage

// ### core/tpc_sync.sv
// two flip-flop synchroniser, one per bit
module tpc_sync #(
	parameter int W = 1
) (
	input wire logic mclk_i, // system clock
	input wire logic rst_n_i, // synchronous reset, active low
	input wire logic [W-1:0] d_i, // asynchronous inputs
	output logic [W-1:0] q_o // synchronised outputs
);
	// one two-stage chain per bit
	for (genvar i = 0; i < W; i++) begin : g_bit
		logic meta_reg; // first stage, read only by the second
		always_ff @(posedge mclk_i) begin
			if (!rst_n_i) begin
				meta_reg <= 1'b0;
				q_o[i] <= 1'b0;
			end else begin
				meta_reg <= d_i[i];
				q_o[i] <= meta_reg;
			end
		end
	end
endmodule

// ### core/tpc_rise.sv
// rising edge detector, one per bit
module tpc_rise #(
	parameter int W = 1
) (
	input wire logic mclk_i, // system clock
	input wire logic rst_n_i, // synchronous reset, active low
	input wire logic [W-1:0] d_i, // synchronised levels
	output logic [W-1:0] rise_o // one-cycle pulse on each rising edge
);
	// keep last level and flag a low to high step
	for (genvar i = 0; i < W; i++) begin : g_bit
		logic last_reg; // level seen one cycle ago
		always_ff @(posedge mclk_i) begin
			if (!rst_n_i) begin
				last_reg <= 1'b0;
			end else begin
				last_reg <= d_i[i];
			end
		end
		assign rise_o[i] = d_i[i] & ~last_reg;
	end
endmodule

// ### core/tpc_top.sv
// tape transport panel control: load, motion, indicators and register slave
// Function
// - on-line: ignore operator motion commands
// - off-line: manual motion only while loaded
// - load starts vacuum, drive; loaded stays
// - forward runs to load/end point or reset
// - backward runs until takeup empties or reset
// - rewind runs fast to load point or reset
// - reset stops any motion
// - reset indicator except during motion or load
// - select shows transport is addressed
// - ready only when operable and on-line
// - load-point and end-point indicators
// - write lock until loaded; ring gates writing
// - write status only on-line while writing
// - nine or seven track, never both
// - rewinding indicator during rewind
// - start switch acts as load
// - brakes release held, power on only
// - unit address 0 to 8, shown
//
// Implementation choices: the register offsets and the Wishbone slave port.
`include "tpc_cfg.svh"
module tpc_top #(
	parameter int ADDR_W = 8 // wishbone address width
) (
	input wire logic mclk_i, // 20 MHz clock
	input wire logic rst_n_i, // synchronous reset, active low
	// wishbone classic slave
	input wire logic wb_cyc_i, // bus cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_we_i, // write enable
	input wire logic [ADDR_W-1:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte lanes
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // acknowledge
	// operator panel and transport sensors
	input wire logic power_on_i, // prime power present
	input wire logic reel_in_i, // file reel installed
	input wire logic tape_in_i, // tape threaded
	input wire logic ring_in_i, // write-enable ring present
	input wire logic load_sw_i, // load switch held
	input wire logic start_sw_i, // slide switch at start
	input wire logic brakes_sw_i, // slide switch at brakes
	input wire logic forward_motion_cmd_i, // forward switch
	input wire logic rev_sw_i, // backward switch
	input wire logic rewind_sw_i, // rewind switch
	input wire logic reset_sw_i, // reset switch
	input wire logic online_sw_i, // on-line switch
	input wire logic offline_sw_i, // off-line switch
	input wire tpc_pkg::tpc_unit_t addr_sw_i, // address thumbwheel
	input wire logic load_pt_i, // load point sensed
	input wire logic end_pt_i, // end point sensed
	input wire logic takeup_empty_i, // tape off takeup reel
	input wire logic vac_ok_i, // tape down in both chambers
	// tape control unit
	input wire tpc_pkg::tpc_unit_t tc_unit_i, // unit number addressed
	input wire logic tc_write_i, // write in progress request
	input wire logic tc_fwd_i, // system forward
	input wire logic tc_rev_i, // system backward
	input wire logic tc_rewind_i, // system rewind
	input wire logic tc_stop_i, // system stop
	// transport drives
	output logic vacuum_on_o, // vacuum system on
	output logic drive_on_o, // tape machinery on
	output logic motor_fwd_o, // forward drive
	output logic motor_rev_o, // backward drive
	output logic motor_hispeed_o, // rewind speed drive
	output logic brake_release_o, // hub brakes released
	output logic write_en_o, // write heads enabled
	// indicators
	output logic ind_load_o, // loaded
	output logic ind_select_o, // addressed
	output logic ind_ready_o, // ready
	output logic ind_load_pt_o, // at load point
	output logic ind_end_pt_o, // at end point
	output logic ind_wr_lock_o, // write lock
	output logic ind_wr_status_o, // writing
	output logic ind_nine_o, // nine track
	output logic ind_seven_o, // seven track
	output logic ind_rewind_o, // rewinding
	output logic ind_reset_o, // reset
	output logic ind_online_o, // on-line
	output logic ind_offline_o, // off-line
	output tpc_pkg::tpc_unit_t ind_addr_o // address selected
);
	import tpc_pkg::*;

	// ****************************************************************
	// pin synchronisation
	// ****************************************************************
	localparam int PIN_W = 30; // pins gathered below
	logic [PIN_W-1:0] pin_raw; // pins as they arrive
	logic [PIN_W-1:0] pin_s; // pins after two flops
	logic [PIN_W-1:0] pin_rise; // rising edges of synced pins
	assign pin_raw = {power_on_i, reel_in_i, tape_in_i, ring_in_i, load_sw_i, start_sw_i,
		brakes_sw_i, forward_motion_cmd_i, rev_sw_i, rewind_sw_i, reset_sw_i, online_sw_i,
		offline_sw_i, load_pt_i, end_pt_i, takeup_empty_i, vac_ok_i, tc_write_i, tc_fwd_i,
		tc_rev_i, tc_rewind_i, tc_stop_i, addr_sw_i, tc_unit_i};

	tpc_sync #(.W(PIN_W)) u_sync (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.d_i(pin_raw),
		.q_o(pin_s)
	);

	tpc_rise #(.W(PIN_W)) u_rise (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.d_i(pin_s),
		.rise_o(pin_rise)
	);

	logic power_s, reel_s, tape_s, ring_s, load_s, start_s, brakes_s; // levels
	logic load_pt_s, end_pt_s, takeup_empty_s, vac_ok_s, tc_write_s; // levels
	tpc_unit_t addr_s, unit_s; // addresses
	logic fwd_r, rev_r, rew_r, rst_r, on_r, off_r, lp_r; // panel and load point edges
	logic tc_fwd_r, tc_rev_r, tc_rew_r, tc_stop_r; // system edges
	assign {power_s, reel_s, tape_s, ring_s, load_s, start_s, brakes_s} = pin_s[29:23];
	assign {load_pt_s, end_pt_s, takeup_empty_s, vac_ok_s, tc_write_s} = pin_s[16:12];
	assign addr_s = pin_s[7:4];
	assign unit_s = pin_s[3:0];
	assign {fwd_r, rev_r, rew_r, rst_r, on_r, off_r, lp_r} = pin_rise[22:16];
	assign {tc_fwd_r, tc_rev_r, tc_rew_r, tc_stop_r} = pin_rise[11:8];

	// ****************************************************************
	// wishbone register slave
	// ****************************************************************
	logic [1:0] ctrl_reg; // nine-track select, software load hold
	logic [5:0] cmd_reg; // one-cycle command pulses
	logic bus_req; // new access this cycle
	logic [31:0] status_word; // assembled status
	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

	// ack one cycle after the strobe, dropped the next
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req;
		end
	end

	// control register, byte lane zero
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			ctrl_reg <= `TPC_CTRL_RST;
		end else if (bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `TPC_OFF_CTRL) begin
			ctrl_reg <= wb_dat_i[1:0];
		end
	end

	// command pulses last exactly one cycle
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			cmd_reg <= 6'h00;
		end else if (bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `TPC_OFF_CMD) begin
			cmd_reg <= wb_dat_i[5:0];
		end else begin
			cmd_reg <= 6'h00;
		end
	end

	// read data, unmapped reads as zero
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (bus_req && !wb_we_i) begin
			case (wb_adr_i)
				`TPC_OFF_STATUS: wb_dat_o <= status_word;
				`TPC_OFF_CTRL: wb_dat_o <= {30'h0000_0000, ctrl_reg};
				default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// ****************************************************************
	// command sources
	// ****************************************************************
	logic online_reg; // on-line mode
	logic loaded; // operable status
	logic load_req; // load held by panel, slide or software
	logic man_fwd, man_rev, man_rew; // operator starts
	logic sys_fwd, sys_rev, sys_rew; // system starts
	logic go_fwd, go_rev, go_rew; // accepted starts
	logic stop_any; // reset request
	assign load_req = load_s | start_s | ctrl_reg[`TPC_CTRL_LOAD];
	assign man_fwd = fwd_r | cmd_reg[`TPC_CMD_FWD];
	assign man_rev = rev_r | cmd_reg[`TPC_CMD_REV];
	assign man_rew = rew_r | cmd_reg[`TPC_CMD_REWIND];
	assign sys_fwd = tc_fwd_r & ind_select_o;
	assign sys_rev = tc_rev_r & ind_select_o;
	assign sys_rew = tc_rew_r & ind_select_o;
	// operator starts count only off-line, system starts only on-line
	assign go_fwd = loaded & (online_reg ? sys_fwd : man_fwd);
	assign go_rev = loaded & (online_reg ? sys_rev : man_rev);
	assign go_rew = loaded & (online_reg ? sys_rew : man_rew);
	assign stop_any = rst_r | cmd_reg[`TPC_CMD_RESET] | (tc_stop_r & ind_select_o);

	// mode switches; off-line after reset
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			online_reg <= 1'b0;
		end else if (off_r || cmd_reg[`TPC_CMD_OFFLINE]) begin
			online_reg <= 1'b0;
		end else if (on_r || cmd_reg[`TPC_CMD_ONLINE]) begin
			online_reg <= 1'b1;
		end
	end

	// ****************************************************************
	// load sequence
	// ****************************************************************
	tpc_load_e load_reg, load_next; // load state
	assign loaded = load_reg == TPC_L_OPERABLE;

	// vacuum and machinery start on load; released load aborts
	always_comb begin
		load_next = load_reg;
		case (load_reg)
			TPC_L_OFF: begin
				if (power_s && tape_s && load_req) begin
					load_next = TPC_L_LOADING;
				end
			end
			TPC_L_LOADING: begin
				if (!power_s || !load_req) begin
					load_next = TPC_L_OFF;
				end else if (vac_ok_s) begin
					load_next = TPC_L_OPERABLE;
				end
			end
			TPC_L_OPERABLE: begin
				if (!power_s || !vac_ok_s) begin
					load_next = TPC_L_OFF; // operable lost
				end
			end
			default: load_next = TPC_L_OFF;
		endcase
	end

	// load state and the drives it owns
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			load_reg <= TPC_L_OFF;
			vacuum_on_o <= 1'b0;
			drive_on_o <= 1'b0;
			ind_load_o <= 1'b0;
		end else begin
			load_reg <= load_next;
			vacuum_on_o <= load_next != TPC_L_OFF;
			drive_on_o <= load_next != TPC_L_OFF;
			ind_load_o <= load_next == TPC_L_OPERABLE;
		end
	end

	// ****************************************************************
	// tape motion
	// ****************************************************************
	tpc_motion_e motion_reg, motion_next; // motion state

	// starts taken only when idle; reset has priority
	always_comb begin
		motion_next = motion_reg;
		case (motion_reg)
			TPC_M_IDLE: begin
				if (stop_any) begin
					motion_next = TPC_M_IDLE;
				end else if (go_rew) begin
					motion_next = TPC_M_REW;
				end else if (go_rev) begin
					motion_next = TPC_M_REV;
				end else if (go_fwd) begin
					motion_next = TPC_M_FWD;
				end
			end
			TPC_M_FWD: begin
				// arriving at load point or at end point stops it
				if (stop_any || lp_r || end_pt_s) begin
					motion_next = TPC_M_IDLE;
				end
			end
			TPC_M_REV: begin
				if (stop_any || takeup_empty_s) begin
					motion_next = TPC_M_IDLE;
				end
			end
			TPC_M_REW: begin
				if (stop_any || load_pt_s) begin
					motion_next = TPC_M_IDLE;
				end
			end
			default: motion_next = TPC_M_IDLE;
		endcase
		// no motion without operable status
		if (load_next != TPC_L_OPERABLE) begin
			motion_next = TPC_M_IDLE;
		end
	end

	// motion state and motor drives
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			motion_reg <= TPC_M_IDLE;
			motor_fwd_o <= 1'b0;
			motor_rev_o <= 1'b0;
			motor_hispeed_o <= 1'b0;
			ind_rewind_o <= 1'b0;
		end else begin
			motion_reg <= motion_next;
			motor_fwd_o <= motion_next == TPC_M_FWD;
			motor_rev_o <= motion_next == TPC_M_REV;
			motor_hispeed_o <= motion_next == TPC_M_REW;
			ind_rewind_o <= motion_next == TPC_M_REW;
		end
	end

	// ****************************************************************
	// indicators and write path
	// ****************************************************************
	logic addr_ok; // thumbwheel inside 0 to 8
	logic sel_next; // addressed by tape control
	logic wr_next; // writing allowed and requested
	assign addr_ok = addr_s <= `TPC_ADDR_MAX;
	tpc_unit_t unit_last_reg, addr_last_reg; // synced words one cycle ago

	// words cross bit by bit; trust them only once steady, hiding skew
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			unit_last_reg <= '0;
			addr_last_reg <= '0;
		end else begin
			unit_last_reg <= unit_s;
			addr_last_reg <= addr_s;
		end
	end
	assign sel_next = addr_ok && (unit_s == addr_s) && (unit_s == unit_last_reg)
		&& (addr_s == addr_last_reg);
	assign wr_next = tc_write_s & online_reg & loaded & ring_s & sel_next;

	// reset shows unless moving or loading
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			ind_reset_o <= 1'b1;
		end else begin
			ind_reset_o <= motion_next == TPC_M_IDLE && load_next != TPC_L_LOADING;
		end
	end

	// write lock lights with power and reel, clears on loaded
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			ind_wr_lock_o <= 1'b0;
		end else begin
			ind_wr_lock_o <= power_s & reel_s & (load_next != TPC_L_OPERABLE);
		end
	end

	// selection, readiness, writing
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			ind_select_o <= 1'b0;
			ind_ready_o <= 1'b0;
			ind_wr_status_o <= 1'b0;
			write_en_o <= 1'b0;
		end else begin
			ind_select_o <= sel_next;
			ind_ready_o <= loaded & online_reg;
			ind_wr_status_o <= wr_next;
			write_en_o <= wr_next;
		end
	end

	// tape position, mode, tracks, address, brakes
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			ind_load_pt_o <= 1'b0;
			ind_end_pt_o <= 1'b0;
			ind_online_o <= 1'b0;
			ind_offline_o <= 1'b1;
			ind_nine_o <= 1'b0;
			ind_seven_o <= 1'b1;
			ind_addr_o <= 4'h0;
			brake_release_o <= 1'b0;
		end else begin
			ind_load_pt_o <= load_pt_s;
			ind_end_pt_o <= end_pt_s;
			ind_online_o <= online_reg;
			ind_offline_o <= ~online_reg;
			ind_nine_o <= ctrl_reg[`TPC_CTRL_NINE];
			ind_seven_o <= ~ctrl_reg[`TPC_CTRL_NINE];
			ind_addr_o <= addr_s;
			brake_release_o <= brakes_s & power_s;
		end
	end

	// status word built from indicator, motor drive and load state flops
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[`TPC_ST_LOADED] = ind_load_o;
		status_word[`TPC_ST_READY] = ind_ready_o;
		status_word[`TPC_ST_SELECT] = ind_select_o;
		status_word[`TPC_ST_LOAD_PT] = ind_load_pt_o;
		status_word[`TPC_ST_END_PT] = ind_end_pt_o;
		status_word[`TPC_ST_WR_LOCK] = ind_wr_lock_o;
		status_word[`TPC_ST_WR_STATUS] = ind_wr_status_o;
		status_word[`TPC_ST_NINE] = ind_nine_o;
		status_word[`TPC_ST_REWIND] = ind_rewind_o;
		status_word[`TPC_ST_RESET] = ind_reset_o;
		status_word[`TPC_ST_ONLINE] = ind_online_o;
		status_word[`TPC_ST_FWD] = motor_fwd_o;
		status_word[`TPC_ST_REV] = motor_rev_o;
		status_word[`TPC_ST_LOADING] = load_reg == TPC_L_LOADING;
		status_word[`TPC_ST_ADDR +: 4] = ind_addr_o;
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_load_go;
		load_reg == TPC_L_OFF && power_s && tape_s && load_req;
	endsequence
	sequence s_load_done;
		load_reg == TPC_L_LOADING && power_s && load_req && vac_ok_s;
	endsequence

	online_ignore_a: assert property (
		online_reg && motion_reg == TPC_M_IDLE && !sys_fwd && !sys_rev && !sys_rew
		|=> motion_reg == TPC_M_IDLE)
		else $error("on-line transport moved without system command");
	offline_gate_a: assert property (
		motion_reg != TPC_M_IDLE |-> $past(load_reg) == TPC_L_OPERABLE)
		else $error("motion without operable status");
	load_start_a: assert property (
		s_load_go |=> vacuum_on_o && drive_on_o && ind_reset_o == 1'b0)
		else $error("load did not start vacuum and drive");
	load_done_a: assert property (
		s_load_done |=> ind_load_o)
		else $error("loaded indication missing");
	load_abort_a: assert property (
		load_reg == TPC_L_LOADING && !load_req |=> !vacuum_on_o)
		else $error("released load not aborted");
	fwd_stop_a: assert property (
		motion_reg == TPC_M_FWD && end_pt_s |=> !motor_fwd_o)
		else $error("forward ran past end point");
	rev_stop_a: assert property (
		motion_reg == TPC_M_REV && takeup_empty_s |=> !motor_rev_o)
		else $error("backward ran off takeup reel");
	rew_stop_a: assert property (
		motion_reg == TPC_M_REW && load_pt_s |=> !motor_hispeed_o && ind_reset_o)
		else $error("rewind did not stop at load point");
	reset_stop_a: assert property (
		stop_any |=> motion_reg == TPC_M_IDLE)
		else $error("reset did not stop motion");
	reset_ind_a: assert property (
		ind_reset_o == !(motor_fwd_o || motor_rev_o || motor_hispeed_o
		|| (vacuum_on_o && !ind_load_o)))
		else $error("reset indicator wrong");
	ready_a: assert property (
		ind_ready_o |-> $past(online_reg) && $past(loaded))
		else $error("ready without operable on-line");
	track_a: assert property (
		ind_nine_o != ind_seven_o)
		else $error("track indications not exclusive");
	brake_a: assert property (
		brake_release_o |-> $past(power_s) && $past(brakes_s))
		else $error("brakes released without power");
endmodule

// ### verif/tpc_tcu_model.sv
// tape control unit model: unit number, write request, system commands
module tpc_tcu_model (
	input wire logic mclk_i, // system clock
	output tpc_pkg::tpc_unit_t tc_unit_o, // unit addressed
	output logic tc_write_o, // write request
	output logic tc_fwd_o, // forward
	output logic tc_rev_o, // backward
	output logic tc_rewind_o, // rewind
	output logic tc_stop_o // stop
);
	timeunit 1ns;
	timeprecision 1ns;
	import tpc_pkg::*;
	// idle: no unit addressed, no command
	initial begin
		tc_unit_o = 4'hf;
		{tc_stop_o, tc_rewind_o, tc_rev_o, tc_fwd_o, tc_write_o} = '0;
	end
	// address one unit, the transport decides if it matches
	task sel(input tpc_unit_t u);
		@(posedge mclk_i) tc_unit_o <= u;
	endtask
	// command held long enough to cross the synchroniser
	task issue(input logic [3:0] c);
		@(posedge mclk_i) {tc_stop_o, tc_rewind_o, tc_rev_o, tc_fwd_o} <= c;
		repeat (4) @(posedge mclk_i);
		{tc_stop_o, tc_rewind_o, tc_rev_o, tc_fwd_o} <= 4'h0;
		repeat (4) @(posedge mclk_i);
	endtask
	// write request level
	task wr(input logic b);
		@(posedge mclk_i) tc_write_o <= b;
	endtask
endmodule

// ### verif/tpc_top_tb.sv
// self-checking bench for the tape transport panel control
`include "tpc_cfg.svh"
module tpc_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import tpc_pkg::*;
	// ****
	// signals
	// ****
	logic mclk_i = 0, rst_n_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h1;
	logic [31:0] wb_dat_i = '0, wb_dat_o, rd;
	logic power_on_i = 0, reel_in_i = 0, tape_in_i = 0, ring_in_i = 0, load_sw_i = 0;
	logic start_sw_i = 0, brakes_sw_i = 0, load_pt_i = 0, end_pt_i = 0;
	logic takeup_empty_i = 0, vac_ok_i = 0, wb_ack_o;
	logic forward_motion_cmd_i, rev_sw_i, rewind_sw_i, reset_sw_i, online_sw_i;
	logic offline_sw_i;
	logic [5:0] sw = '0; // panel switches, one bit each
	tpc_unit_t addr_sw_i = 4'h5, tc_unit_i, ind_addr_o;
	logic tc_write_i, tc_fwd_i, tc_rev_i, tc_rewind_i, tc_stop_i;
	logic vacuum_on_o, drive_on_o, motor_fwd_o, motor_rev_o, motor_hispeed_o;
	logic brake_release_o, write_en_o, ind_load_o, ind_select_o, ind_ready_o;
	logic ind_load_pt_o, ind_end_pt_o, ind_wr_lock_o, ind_wr_status_o, ind_nine_o;
	logic ind_seven_o, ind_rewind_o, ind_reset_o, ind_online_o, ind_offline_o;
	int n_fail = 0, checks_done = 0;
	assign {offline_sw_i, online_sw_i, reset_sw_i, rewind_sw_i, rev_sw_i} = sw[5:1];
	assign forward_motion_cmd_i = sw[0];
	tpc_top dut_u (.*);
	tpc_tcu_model tcu_u (.mclk_i(mclk_i), .tc_unit_o(tc_unit_i), .tc_write_o(tc_write_i),
		.tc_fwd_o(tc_fwd_i), .tc_rev_o(tc_rev_i), .tc_rewind_o(tc_rewind_i),
		.tc_stop_o(tc_stop_i));
	always #25 mclk_i = ~mclk_i; // 20 MHz
	// ****
	// shared tasks
	// ****
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task wt(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	// classic single cycle, held until ack is seen
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s = 4'h1);
		@(posedge mclk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		do @(posedge mclk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	// press and release one panel switch
	task tap(input int k);
		@(posedge mclk_i) sw[k] <= 1'b1;
		wt(4);
		@(posedge mclk_i) sw[k] <= 1'b0;
		wt(6);
	endtask
	// ****
	// scenarios
	// ****
	task t_reset;
		wt(3);
		chk({ind_reset_o, ind_nine_o, ind_seven_o}, 3'b110);
		wb(1'b1, `TPC_OFF_CTRL, '0);
		wt(2);
		chk({ind_nine_o, ind_seven_o}, 2'b01);
		wb(1'b1, `TPC_OFF_CTRL, 32'h0000_0001, 4'he);
		wb(1'b0, `TPC_OFF_CTRL, '0);
		chk(rd, '0); // lane zero off: write ignored
		wb(1'b0, 8'h0c, '0);
		chk(rd, '0); // unmapped place reads zero
		@(posedge mclk_i) addr_sw_i <= 4'h9;
		tcu_u.sel(4'h9);
		wt(6);
		chk({ind_select_o, ind_addr_o}, 5'h09);
		@(posedge mclk_i) addr_sw_i <= 4'h8;
		tcu_u.sel(4'h8);
		wt(6);
		chk({ind_select_o, ind_addr_o}, 5'h18);
		@(posedge mclk_i) addr_sw_i <= 4'h5;
		tcu_u.sel(4'hf);
		wt(6);
		chk(ind_addr_o, 4'h5);
	endtask
	task t_load;
		@(posedge mclk_i) power_on_i <= 1'b1;
		reel_in_i <= 1'b1;
		tape_in_i <= 1'b1;
		wt(5);
		chk(ind_wr_lock_o, 1'b1);
		@(posedge mclk_i) start_sw_i <= 1'b1;
		wt(6);
		chk({vacuum_on_o, drive_on_o, ind_reset_o, ind_load_o}, 4'b1100);
		@(posedge mclk_i) vac_ok_i <= 1'b1;
		while (ind_load_o !== 1'b1) wt(1);
		@(posedge mclk_i) start_sw_i <= 1'b0;
		wt(6);
		chk({ind_load_o, ind_wr_lock_o, ind_reset_o}, 3'b101);
		wb(1'b0, `TPC_OFF_STATUS, '0);
		chk({rd[19:16], rd[0]}, 5'h0b);
	endtask
	task t_manual;
		tap(0);
		chk({motor_fwd_o, ind_reset_o}, 2'b10);
		@(posedge mclk_i) load_pt_i <= 1'b1;
		wt(6);
		chk({motor_fwd_o, ind_reset_o, ind_load_pt_o}, 3'b011);
		tap(1);
		chk(motor_rev_o, 1'b1);
		@(posedge mclk_i) takeup_empty_i <= 1'b1;
		wt(6);
		chk(motor_rev_o, 1'b0);
		@(posedge mclk_i) takeup_empty_i <= 1'b0;
		load_pt_i <= 1'b0;
		tap(2);
		chk({motor_hispeed_o, ind_rewind_o}, 2'b11);
		tap(3);
		chk({motor_hispeed_o, ind_rewind_o, ind_reset_o}, 3'b001);
		tap(2);
		@(posedge mclk_i) load_pt_i <= 1'b1;
		wt(6);
		chk({motor_hispeed_o, ind_load_pt_o}, 2'b01);
		@(posedge mclk_i) end_pt_i <= 1'b1;
		tap(0);
		chk({motor_fwd_o, ind_end_pt_o}, 2'b01);
		@(posedge mclk_i) end_pt_i <= 1'b0;
	endtask
	task t_online;
		tap(4);
		chk({ind_ready_o, ind_online_o, ind_offline_o}, 3'b110);
		tap(0);
		chk(motor_fwd_o, 1'b0);
		tcu_u.sel(4'h3);
		wt(6);
		chk(ind_select_o, 1'b0);
		tcu_u.sel(4'h5);
		wt(6);
		chk(ind_select_o, 1'b1);
		tcu_u.issue(4'b0001);
		wt(1);
		chk(motor_fwd_o, 1'b1);
		tcu_u.issue(4'b1000);
		wt(1);
		chk(motor_fwd_o, 1'b0);
		tcu_u.issue(4'b0010);
		tcu_u.issue(4'b0100);
		wt(1);
		chk({motor_rev_o, motor_hispeed_o}, 2'b10);
		tcu_u.issue(4'b1000);
		@(posedge mclk_i) load_pt_i <= 1'b0;
		tcu_u.issue(4'b0100);
		wt(1);
		chk({motor_hispeed_o, ind_rewind_o, motor_rev_o}, 3'b110);
		@(posedge mclk_i) load_pt_i <= 1'b1;
		wt(6);
		chk({motor_hispeed_o, ind_reset_o}, 2'b01);
		tcu_u.wr(1'b1);
		wt(6);
		chk({ind_wr_status_o, write_en_o}, 2'b00);
		@(posedge mclk_i) ring_in_i <= 1'b1;
		wt(6);
		chk({ind_wr_status_o, write_en_o}, 2'b11);
		wb(1'b1, `TPC_OFF_CMD, 32'h0000_0020);
		wt(6);
		chk({ind_ready_o, ind_wr_status_o, ind_offline_o}, 3'b001);
		wb(1'b1, `TPC_OFF_CMD, 32'h0000_0001);
		wt(2);
		chk(motor_fwd_o, 1'b1);
		wb(1'b1, `TPC_OFF_CMD, 32'h0000_0008);
		wt(2);
		chk({motor_fwd_o, ind_reset_o}, 2'b01);
		tcu_u.wr(1'b0);
	endtask
	task t_brakes;
		@(posedge mclk_i) brakes_sw_i <= 1'b1;
		wt(6);
		chk(brake_release_o, 1'b1);
		@(posedge mclk_i) power_on_i <= 1'b0;
		wt(6);
		chk({brake_release_o, ind_load_o}, 2'b00);
		@(posedge mclk_i) vac_ok_i <= 1'b0;
		power_on_i <= 1'b1;
		load_sw_i <= 1'b1;
		wt(6);
		chk({vacuum_on_o, ind_load_o, brake_release_o}, 3'b101);
		@(posedge mclk_i) load_sw_i <= 1'b0;
		brakes_sw_i <= 1'b0;
		wt(6);
		chk({vacuum_on_o, ind_reset_o, brake_release_o}, 3'b010);
	endtask
	// ****
	// verdict, main sequence and watchdog
	// ****
	task end_of_test;
		if (n_fail == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		t_reset;
		t_load;
		t_manual;
		t_online;
		t_brakes;
		end_of_test;
	end
	// all scenarios take well under a thousand cycles
	initial begin
		repeat (4000) @(posedge mclk_i);
		n_fail++;
		end_of_test;
	end
endmodule
